//--- core/ptm_sensor_i2c.sv
// i2c target, register map and conversion sequencer of the sensor
`default_nettype none
module ptm_sensor_i2c #(
    parameter int CONV_CYC = ptm_pkg::CONV_PHASE_CYC,
    parameter int IDLE_CYC = ptm_pkg::IDLE_STEP_CYC
) (
    // clock, reset, enable
    input  wire logic                 core_clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 ce_i,
    // i2c pins
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    // analog front end
    input  wire ptm_pkg::ptm_sample_t sample_i,
    output ptm_pkg::ptm_fe_ctl_t      fe_ctl_o
);
    import ptm_pkg::*;

    // pin synchronisers and edge history
    logic        scl_s1_ff;
    logic        scl_s2_ff;
    logic        scl_d_ff;
    logic        sda_s1_ff;
    logic        sda_s2_ff;
    logic        sda_d_ff;
    // i2c engine
    ptm_i2c_st_t st_ff;
    ptm_i2c_st_t nxt_st;
    logic [3:0]  cnt_ff;
    logic [3:0]  nxt_cnt;
    logic [7:0]  shift_ff;
    logic [7:0]  nxt_shift;
    logic        first_ff;
    logic        nxt_first;
    logic        ptr_phase_ff;
    logic        nxt_ptr_phase;
    logic        read_ff;
    logic        nxt_read;
    logic [7:0]  ptr_ff;
    logic [7:0]  nxt_ptr;
    logic        oe_ff;
    logic        nxt_oe;
    logic        wr_en;
    // registers
    logic [7:0]  meas_ff;
    logic [7:0]  sys_ff;
    logic [7:0]  pch_ff;
    logic [23:0] p_res_ff;
    logic [15:0] t_res_ff;
    logic [15:0] t_hold_ff;
    // conversion sequencer
    ptm_cv_st_t  cv_ff;
    ptm_cv_st_t  nxt_cv;
    logic [31:0] tmr_ff;
    logic [31:0] nxt_tmr;
    logic        clr_go;
    logic        commit;
    logic        hold_temp;

    // bus events, all from synchronised copies
    wire scl_rise = scl_s2_ff & ~scl_d_ff;
    wire scl_fall = ~scl_s2_ff & scl_d_ff;
    wire scl_hi   = scl_s2_ff & scl_d_ff;
    wire bus_start = scl_hi & sda_d_ff & ~sda_s2_ff;
    wire bus_stop  = scl_hi & ~sda_d_ff & sda_s2_ff;
    wire byte_done = scl_fall & (cnt_ff == BYTE_BITS);
    wire addr_hit  = shift_ff[7:1] == DEV_ADDR;

    // register fields
    wire [3:0] idle_code = meas_ff[MC_IDLE_HI:MC_IDLE_LO];
    wire       go_bit    = meas_ff[MC_GO_BIT];
    wire [2:0] kind      = meas_ff[MC_KIND_HI:0];
    wire       raw_sel   = sys_ff[SYS_RAW_BIT];
    wire       uns_sel   = sys_ff[SYS_UNS_BIT] & raw_sel;
    wire       kind_ok   = (kind == KIND_COMBINED) |
                           (kind == KIND_PERIODIC);
    wire       periodic  = kind == KIND_PERIODIC;

    // output selection, calibrated unless raw requested
    wire [23:0] p_pick = raw_sel ? sample_i.raw_press
                                 : sample_i.cal_press;
    wire [15:0] t_pick = raw_sel ? sample_i.raw_temp
                                 : sample_i.cal_temp;
    // offset binary by flipping the sign bit
    wire [23:0] p_sel = uns_sel ? p_pick ^ P_SIGN : p_pick;
    wire [15:0] t_sel = uns_sel ? t_pick ^ T_SIGN : t_pick;

    // read data mux, unmapped offsets read zero
    wire [7:0] rd_byte =
        (ptr_ff == REG_P_HIGH) ? p_res_ff[23:16] :
        (ptr_ff == REG_P_MID)  ? p_res_ff[15:8]  :
        (ptr_ff == REG_P_LOW)  ? p_res_ff[7:0]   :
        (ptr_ff == REG_T_HIGH) ? t_res_ff[15:8]  :
        (ptr_ff == REG_T_LOW)  ? t_res_ff[7:0]   :
        (ptr_ff == REG_MEAS)   ? meas_ff         :
        (ptr_ff == REG_SYS)    ? sys_ff          :
        (ptr_ff == REG_PCH)    ? pch_ff          : 8'h00;

    wire wr_meas = wr_en & (ptr_ff == REG_MEAS);
    wire wr_sys  = wr_en & (ptr_ff == REG_SYS);
    wire wr_pch  = wr_en & (ptr_ff == REG_PCH);
    // host setting go wins over the sequencer's clear
    wire go_next = wr_meas ? shift_ff[MC_GO_BIT]
                           : go_bit & ~clr_go;

    // sda only moves on a seen scl fall, so never while scl is high
    always_comb
    begin
        nxt_st        = st_ff;
        nxt_cnt       = cnt_ff;
        nxt_shift     = shift_ff;
        nxt_first     = first_ff;
        nxt_ptr_phase = ptr_phase_ff;
        nxt_read      = read_ff;
        nxt_ptr       = ptr_ff;
        nxt_oe        = oe_ff;
        wr_en         = 1'b0;
        unique case (st_ff)
            ST_IDLE:
            begin
                nxt_oe = 1'b0;
            end
            ST_RX:
            begin
                if (scl_rise)
                begin
                    nxt_shift = {shift_ff[6:0], sda_s2_ff};
                    nxt_cnt   = cnt_ff + 4'h1;
                end
                if (byte_done)
                begin
                    nxt_cnt = 4'h0;
                    if (first_ff)
                    begin
                        nxt_first = 1'b0;
                        nxt_read  = shift_ff[0];
                        nxt_st    = addr_hit ? ST_ACK : ST_IDLE;
                        nxt_oe    = addr_hit;
                    end
                    else if (ptr_phase_ff)
                    begin
                        nxt_ptr_phase = 1'b0;
                        nxt_ptr       = shift_ff;
                        nxt_st        = ST_ACK;
                        nxt_oe        = 1'b1;
                    end
                    else
                    begin
                        wr_en   = 1'b1;
                        nxt_ptr = ptr_ff + 8'h01;
                        nxt_st  = ST_ACK;
                        nxt_oe  = 1'b1;
                    end
                end
            end
            ST_ACK:
            begin
                if (scl_fall)
                begin
                    nxt_cnt = 4'h0;
                    if (read_ff)
                    begin
                        nxt_shift = rd_byte;
                        nxt_ptr   = ptr_ff + 8'h01;
                        nxt_oe    = ~rd_byte[7];
                        nxt_st    = ST_TX;
                    end
                    else
                    begin
                        nxt_oe = 1'b0;
                        nxt_st = ST_RX;
                    end
                end
            end
            ST_TX:
            begin
                if (scl_rise)
                begin
                    nxt_cnt = cnt_ff + 4'h1;
                end
                if (byte_done)
                begin
                    nxt_oe = 1'b0;
                    nxt_st = ST_RACK;
                end
                else if (scl_fall)
                begin
                    nxt_shift = {shift_ff[6:0], 1'b0};
                    nxt_oe    = ~shift_ff[6];
                end
            end
            ST_RACK:
            begin
                // nack ends the read, ack fetches the next byte
                if (scl_rise)
                begin
                    nxt_st = sda_s2_ff ? ST_IDLE : ST_ACK;
                end
            end
            default:
            begin
                nxt_st = ST_IDLE;
                nxt_oe = 1'b0;
            end
        endcase
        if (bus_start)
        begin
            nxt_st        = ST_RX;
            nxt_cnt       = 4'h0;
            nxt_first     = 1'b1;
            nxt_ptr_phase = 1'b1;
            nxt_oe        = 1'b0;
        end
        else if (bus_stop)
        begin
            nxt_st = ST_IDLE;
            nxt_oe = 1'b0;
        end
    end

    // conversion sequencer
    always_comb
    begin
        nxt_cv    = cv_ff;
        nxt_tmr   = tmr_ff;
        clr_go    = 1'b0;
        commit    = 1'b0;
        hold_temp = 1'b0;
        unique case (cv_ff)
            CV_IDLE:
            begin
                if (go_bit & kind_ok)
                begin
                    nxt_cv  = CV_TEMP;
                    nxt_tmr = 32'(CONV_CYC - 1);
                end
                else if (go_bit)
                begin
                    // nothing to run for other kinds
                    clr_go = 1'b1;
                end
            end
            CV_TEMP:
            begin
                if (tmr_ff == 32'h0)
                begin
                    hold_temp = 1'b1;
                    nxt_cv    = CV_PRESS;
                    nxt_tmr   = 32'(CONV_CYC - 1);
                end
                else
                begin
                    nxt_tmr = tmr_ff - 32'h1;
                end
            end
            CV_PRESS:
            begin
                if (tmr_ff == 32'h0)
                begin
                    commit = 1'b1;
                    if (periodic & go_bit)
                    begin
                        nxt_cv  = CV_WAIT;
                        nxt_tmr = 32'(idle_code) *
                                  32'(IDLE_CYC);
                    end
                    else
                    begin
                        nxt_cv = CV_IDLE;
                        clr_go = ~periodic;
                    end
                end
                else
                begin
                    nxt_tmr = tmr_ff - 32'h1;
                end
            end
            CV_WAIT:
            begin
                if (~go_bit | ~periodic)
                begin
                    nxt_cv = CV_IDLE;
                end
                else if (tmr_ff == 32'h0)
                begin
                    nxt_cv  = CV_TEMP;
                    nxt_tmr = 32'(CONV_CYC - 1);
                end
                else
                begin
                    nxt_tmr = tmr_ff - 32'h1;
                end
            end
        endcase
    end

    // synchronisers; stage one feeds stage two only
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_d_ff  <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_d_ff  <= 1'b1;
        end
        else if (ce_i)
        begin
            scl_s1_ff <= scl_i;
            scl_s2_ff <= scl_s1_ff;
            scl_d_ff  <= scl_s2_ff;
            sda_s1_ff <= sda_i;
            sda_s2_ff <= sda_s1_ff;
            sda_d_ff  <= sda_s2_ff;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_ff        <= ST_IDLE;
            cnt_ff       <= 4'h0;
            shift_ff     <= 8'h00;
            first_ff     <= 1'b0;
            ptr_phase_ff <= 1'b0;
            read_ff      <= 1'b0;
            ptr_ff       <= 8'h00;
            oe_ff        <= 1'b0;
        end
        else if (ce_i)
        begin
            st_ff        <= nxt_st;
            cnt_ff       <= nxt_cnt;
            shift_ff     <= nxt_shift;
            first_ff     <= nxt_first;
            ptr_phase_ff <= nxt_ptr_phase;
            read_ff      <= nxt_read;
            ptr_ff       <= nxt_ptr;
            oe_ff        <= nxt_oe;
        end
    end

    // writable registers
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meas_ff <= MEAS_RST;
            sys_ff  <= SYS_RST;
            pch_ff  <= PCH_RST;
        end
        else if (ce_i)
        begin
            meas_ff[MC_GO_BIT] <= go_next;
            if (wr_meas)
            begin
                meas_ff[MC_IDLE_HI:MC_IDLE_LO] <=
                    shift_ff[MC_IDLE_HI:MC_IDLE_LO];
                meas_ff[MC_KIND_HI:0] <= shift_ff[MC_KIND_HI:0];
            end
            if (wr_sys)
            begin
                sys_ff <= shift_ff;
            end
            if (wr_pch)
            begin
                pch_ff <= shift_ff & PCH_RW_MASK;
            end
        end
    end

    // results: temperature held until pressure lands, then both at once
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cv_ff     <= CV_IDLE;
            tmr_ff    <= 32'h0;
            t_hold_ff <= T_RES_RST;
            p_res_ff  <= P_RES_RST;
            t_res_ff  <= T_RES_RST;
        end
        else if (ce_i)
        begin
            cv_ff  <= nxt_cv;
            tmr_ff <= nxt_tmr;
            if (hold_temp)
            begin
                t_hold_ff <= t_sel;
            end
            if (commit)
            begin
                p_res_ff <= p_sel;
                t_res_ff <= t_hold_ff;
            end
        end
    end

    // pins and front-end controls, all registered
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
            fe_ctl_o <= '0;
        end
        else if (ce_i)
        begin
            sda_o                    <= 1'b0;
            sda_oe_o                 <= nxt_oe;
            fe_ctl_o.temp_busy       <= nxt_cv == CV_TEMP;
            fe_ctl_o.press_busy      <= nxt_cv == CV_PRESS;
            fe_ctl_o.input_swap      <= pch_ff[PCH_SWAP_BIT];
            fe_ctl_o.diag_en         <= sys_ff[SYS_DIAG_BIT];
            fe_ctl_o.regulator_level <= sys_ff[SYS_LDO_BIT];
            fe_ctl_o.gain <= pch_ff[PCH_GAIN_HI:PCH_GAIN_LO];
            fe_ctl_o.osr  <= pch_ff[PCH_OSR_HI:0];
        end
    end
endmodule
`default_nettype wire

//--- core/ptm_pkg.sv
// constants, types and register map of the pressure/temperature target
`default_nettype none
package ptm_pkg;
    // bus address of the target
    localparam logic [6:0]  DEV_ADDR      = 7'h6d;
    // register offsets
    localparam logic [7:0]  REG_P_HIGH    = 8'h06;
    localparam logic [7:0]  REG_P_MID     = 8'h07;
    localparam logic [7:0]  REG_P_LOW     = 8'h08;
    localparam logic [7:0]  REG_T_HIGH    = 8'h09;
    localparam logic [7:0]  REG_T_LOW     = 8'h0a;
    localparam logic [7:0]  REG_MEAS      = 8'h30;
    localparam logic [7:0]  REG_SYS       = 8'ha5;
    localparam logic [7:0]  REG_PCH       = 8'ha6;
    // reset values
    localparam logic [7:0]  MEAS_RST      = 8'h00;
    localparam logic [7:0]  SYS_RST       = 8'h01;
    localparam logic [7:0]  PCH_RST       = 8'h00;
    localparam logic [23:0] P_RES_RST     = 24'h000000;
    localparam logic [15:0] T_RES_RST     = 16'h0000;
    // measurement_control fields
    localparam int          MC_IDLE_HI    = 7;
    localparam int          MC_IDLE_LO    = 4;
    localparam int          MC_GO_BIT     = 3;
    localparam int          MC_KIND_HI    = 2;
    localparam logic [2:0]  KIND_COMBINED = 3'h2;
    localparam logic [2:0]  KIND_PERIODIC = 3'h3;
    // system_setup fields
    localparam int          SYS_DIAG_BIT  = 0;
    localparam int          SYS_RAW_BIT   = 1;
    localparam int          SYS_UNS_BIT   = 2;
    localparam int          SYS_LDO_BIT   = 3;
    // pressure_channel_setup fields, bit 6 reserved
    localparam int          PCH_SWAP_BIT  = 7;
    localparam int          PCH_GAIN_HI   = 5;
    localparam int          PCH_GAIN_LO   = 3;
    localparam int          PCH_OSR_HI    = 2;
    localparam logic [7:0]  PCH_RW_MASK   = 8'hbf;
    // sign bits flipped for unsigned raw output
    localparam logic [23:0] P_SIGN        = 24'h800000;
    localparam logic [15:0] T_SIGN        = 16'h8000;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    // timing
    localparam int          CLK_KHZ       = 25000;
    localparam int          CONV_TIME_US  = 5000;
    localparam int          IDLE_STEP_US  = 62500;
    localparam int          CONV_PHASE_CYC =
        CONV_TIME_US * CLK_KHZ / 1000 / 2;
    localparam int          IDLE_STEP_CYC =
        IDLE_STEP_US * CLK_KHZ / 1000;

    typedef struct packed {
        logic [23:0] cal_press;
        logic [23:0] raw_press;
        logic [15:0] cal_temp;
        logic [15:0] raw_temp;
    } ptm_sample_t;

    typedef struct packed {
        logic       temp_busy;
        logic       press_busy;
        logic       input_swap;
        logic       diag_en;
        logic       regulator_level;
        logic [2:0] gain;
        logic [2:0] osr;
    } ptm_fe_ctl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX   = 3'h1,
        ST_ACK  = 3'h2,
        ST_TX   = 3'h3,
        ST_RACK = 3'h4
    } ptm_i2c_st_t;

    typedef enum logic [1:0] {
        CV_IDLE  = 2'h0,
        CV_TEMP  = 2'h1,
        CV_PRESS = 2'h2,
        CV_WAIT  = 2'h3
    } ptm_cv_st_t;
endpackage
`default_nettype wire

//--- test/ptm_sensor_i2c_props.sv
// pin-level assertions of the sensor i2c target
`default_nettype none
module ptm_sensor_i2c_props #(
    parameter int CONV_CYC = 20,
    parameter int IDLE_CYC = 10
) (
    // clock, reset and enable
    input wire logic                 core_clk_i,
    input wire logic                 arst_n_i,
    input wire logic                 ce_i,
    // i2c pins
    input wire logic                 scl_i,
    input wire logic                 sda_i,
    input wire logic                 sda_o,
    input wire logic                 sda_oe_o,
    // front end
    input wire ptm_pkg::ptm_sample_t sample_i,
    input wire ptm_pkg::ptm_fe_ctl_t fe_ctl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ptm_pkg::*;
    logic busy;
    int   busy_cnt_ff;

    assign busy = fe_ctl_o.temp_busy | fe_ctl_o.press_busy;

    // length of one combined conversion
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            busy_cnt_ff <= 0;
        else if (ce_i)
            busy_cnt_ff <= busy ? busy_cnt_ff + 1 : 0;
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    AST_SDA_ZERO: assert property (sda_o == 1'b0)
        else $error("sda value not low");
    AST_OE_SCL_LOW: assert property (
        $changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
        else $error("sda drive changed while scl high");
    AST_ACK_HOLD: assert property (
        $rose(sda_oe_o) |-> sda_oe_o [*8])
        else $error("sda pull released early");
    AST_BUSY_EXCL: assert property (
        !(fe_ctl_o.temp_busy && fe_ctl_o.press_busy))
        else $error("both phases busy");
    AST_TEMP_THEN_PRESS: assert property (
        $fell(fe_ctl_o.temp_busy) |-> fe_ctl_o.press_busy)
        else $error("pressure phase did not follow");
    AST_PRESS_AFTER_TEMP: assert property (
        $rose(fe_ctl_o.press_busy) |-> $past(fe_ctl_o.temp_busy))
        else $error("pressure phase without temperature");
    AST_CONV_LEN: assert property (
        $fell(busy) |-> busy_cnt_ff == 2 * CONV_CYC)
        else $error("conversion length wrong");
    AST_DIAG_DEFAULT: assert property (
        arst_n_i && !$past(arst_n_i) |=> fe_ctl_o.diag_en)
        else $error("diagnosis not on after reset");

    cover property ($rose(sda_oe_o));
    cover property ($rose(fe_ctl_o.temp_busy));
    cover property ($fell(fe_ctl_o.press_busy));
endmodule

bind ptm_sensor_i2c ptm_sensor_i2c_props #(
    .CONV_CYC (CONV_CYC),
    .IDLE_CYC (IDLE_CYC)
) i_props (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .sample_i   (sample_i),
    .fe_ctl_o   (fe_ctl_o)
);
`default_nettype wire

//--- test/ptm_i2c_ctl_model.sv
// i2c bus controller model facing the sensor target
`default_nettype none
module ptm_i2c_ctl_model (
    // bus wires
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ptm_pkg::*;
    logic [6:0] dev = DEV_ADDR;
    logic [8:0] res;
    event       got;

    // scl idles high between frames
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic note(input logic [8:0] x);
        res = x;
        -> got;
    endtask

    // long low phase: target answers three core clocks after a fall
    task automatic bit_io(input logic b, output logic r);
        #40 sda_oe_o = !b;
        #160 scl_o = 1'b1;
        r = sda_i;
        #120 scl_o = 1'b0;
    endtask

    task automatic cond(input logic stop);
        #40 sda_oe_o = stop;
        #160 scl_o = 1'b1;
        #120 sda_oe_o = !stop;
        #120 scl_o = stop;
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask

    // pointer write, then one data byte or a read burst of n
    task automatic xfer(input logic [7:0] ptr, input logic rd, input int n,
                        input logic [7:0] wd, input logic chk,
                        output logic [7:0] d);
        logic ack;
        cond(1'b0);
        send({dev, 1'b0}, ack);
        if (chk)
            note({8'h80, ack});
        send(ptr, ack);
        if (!rd)
            send(wd, ack);
        else
        begin
            cond(1'b0);
            send({dev, 1'b1}, ack);
            for (int i = 0; i < n; i++)
            begin
                recv(i == n - 1, d);
                if (chk)
                    note({1'b0, d});
            end
        end
        cond(1'b1);
    endtask
endmodule
`default_nettype wire

//--- test/ptm_sensor_i2c_tb_top.sv
// self-checking bench of the sensor i2c target
`default_nettype none
module ptm_sensor_i2c_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ptm_pkg::*;
    localparam logic [7:0] ADDRS [9] = '{REG_P_HIGH, REG_P_MID, REG_P_LOW,
        REG_T_HIGH, REG_T_LOW, REG_MEAS, REG_SYS, REG_PCH, 8'h40};
    localparam logic [7:0] RSTS [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        MEAS_RST, SYS_RST, PCH_RST, 8'h00};
    localparam logic [7:0] MODES [4] = '{8'h01, 8'h02, 8'h0e, 8'h04};
    localparam int CONV_T = 20;
    localparam int IDLE_T = 10;
    logic        clk;
    logic        arst_n = 1'b0;
    logic        scl;
    logic        ctl_oe;
    logic        dut_oe;
    logic        dut_sda;
    logic        sda;
    time         t_mark;
    ptm_sample_t sample = '0;
    ptm_fe_ctl_t fe_ctl;
    logic [8:0]  exp_q[$];
    int          n_fail = 0;
    int          num_checks = 0;
    int          seed = 78;
    logic [7:0]  v;
    logic [7:0]  b;
    logic [7:0]  s;
    logic [95:0] rnd;

    // pull-up on the line; the target's driven value counts while enabled
    assign sda = !ctl_oe & (dut_oe ? dut_sda : 1'b1);

    ptm_sensor_i2c #(
        .CONV_CYC (CONV_T),
        .IDLE_CYC (IDLE_T)
    ) i_dut (
        .core_clk_i (clk),
        .arst_n_i   (arst_n),
        .ce_i       (1'b1),
        .scl_i      (scl),
        .sda_i      (sda),
        .sda_o      (dut_sda),
        .sda_oe_o   (dut_oe),
        .sample_i   (sample),
        .fe_ctl_o   (fe_ctl)
    );

    ptm_i2c_ctl_model i_ctl (
        .sda_i    (sda),
        .scl_o    (scl),
        .sda_oe_o (ctl_oe)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        exp_q.push_back({8'h80, i_ctl.dev == DEV_ADDR});
        i_ctl.xfer(a, 1'b0, 0, d, 1'b1, x);
    endtask

    task automatic rd(input logic [7:0] a, input int n, input logic [39:0] e);
        logic [7:0] x;
        exp_q.push_back(9'h101);
        for (int i = n - 1; i >= 0; i--)
            exp_q.push_back({1'b0, e[8*i +: 8]});
        i_ctl.xfer(a, 1'b1, n, 8'h00, 1'b1, x);
    endtask

    // keeps the link phase 7 ns off the core falling edge
    task automatic new_sample;
        @(negedge clk);
        rnd = {$random(seed), $random(seed), $random(seed)};
        sample = rnd[79:0];
        #7;
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(i_ctl.got)
        check(i_ctl.res, exp_q.pop_front());

    initial
    begin
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        #7;
        for (int i = 0; i < 9; i++)
            rd(ADDRS[i], 1, 40'(RSTS[i]));
        wr(REG_P_HIGH, 8'hff);
        rd(REG_P_HIGH, 5, 40'h0);
        v = 8'($random(seed));
        wr(REG_PCH, v);
        rd(REG_PCH, 1, 40'(v & PCH_RW_MASK));
        i_ctl.dev = DEV_ADDR ^ 7'h01;
        wr(REG_PCH, ~v);
        i_ctl.dev = DEV_ADDR;
        rd(REG_PCH, 1, 40'(v & PCH_RW_MASK));
        foreach (MODES[m])
        begin
            s = MODES[m];
            new_sample;
            wr(REG_SYS, s);
            wr(REG_MEAS, 8'h0a);
            b = 8'hff;
            for (int k = 0; k < 20 && b[MC_GO_BIT]; k++)
                i_ctl.xfer(REG_MEAS, 1'b1, 1, 8'h00, 1'b0, b);
            exp_q.push_back(9'h002);
            i_ctl.note({1'b0, b});
            rd(REG_P_HIGH, 5, !s[SYS_RAW_BIT]
                ? {sample.cal_press, sample.cal_temp}
                : {sample.raw_press ^ (s[SYS_UNS_BIT] ? P_SIGN : 24'h0),
                   sample.raw_temp ^ (s[SYS_UNS_BIT] ? T_SIGN : 16'h0)});
            exp_q.push_back({v[7], s[0], s[3], v[5:0]});
            i_ctl.note(fe_ctl[8:0]);
        end
        wr(REG_SYS, SYS_RST);
        // unknown kind: go drops again and nothing runs
        wr(REG_MEAS, 8'h09);
        rd(REG_MEAS, 1, 40'h01);
        wr(REG_MEAS, 8'h1b);
        // start to start: two phases plus one idle step and one cycle
        @(posedge fe_ctl.temp_busy);
        t_mark = $time;
        @(posedge fe_ctl.temp_busy);
        exp_q.push_back(9'(2 * CONV_T + IDLE_T + 1));
        i_ctl.note(9'(($time - t_mark) / 40));
        new_sample;
        #12000;
        rd(REG_MEAS, 1, 40'h1b);
        rd(REG_P_HIGH, 5, {sample.cal_press, sample.cal_temp});
        wr(REG_MEAS, 8'h00);
        complete_run;
    end

    initial
    begin
        #2000000;
        n_fail++;
        complete_run;
    end
endmodule
`default_nettype wire
